// ==== rtl/vsfm_top.sv ====
// sample sequencer, word buffer, frame serializer and diff encoder
// Function
// - sample ten channels in turn, serialize
// - differentially encode output for quadriphase
// - one of two commanded modes
// - 2 ms alternating preamble per frame
// - 56-bit sync and line id follow
// - capture 12-bit line id once per scan
// - visual 6-bit, infrared 8-bit words
// - half mode drops words six to nine
// - half mode: four paired visuals, two infrared
// - 28 Mb/s full, 14 Mb/s half
// - only selected redundant converter feeds stream
// - half mode holds odd visual group
`timescale 1ns/10ps
`include "vsfm_defs.svh"

module vsfm_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];    // flip-flop storage
    logic [AW-1:0] wp_r;        // write index
    logic [AW-1:0] rp_r;        // read index
    logic [AW:0]   cnt_r;       // fill level
    logic          push;
    logic          pop;

    // room while the level is below the depth, empty included
    assign in_ready  = (cnt_r < (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write, no reset needed for data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vsfm_fifo

module vsfm_top
    import vsfm_pkg::*;
#(
    parameter int unsigned PREAMBLE_US      = `VSFM_PRE_US,
    parameter int unsigned SAMPLES_PER_LINE = `VSFM_SAMPLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // ground command and redundancy selects
    input  wire logic        mode_cmd,
    input  wire logic        vis_unit_sel,
    input  wire logic        ir_unit_sel,
    // scan instrument
    input  wire logic        line_start,
    input  wire logic [11:0] line_id,
    // converters
    input  wire logic        conv_done,
    input  vsfm_codes_s      conv_codes,
    output vsfm_req_s        conv_req,
    output logic             pair_sum_en,
    output logic             grp_even,
    // status
    output logic             mode_act,
    output logic             frame_busy,
    output logic             underrun,
    // serial stream and modulator symbols
    output logic             ser_bit,
    output logic             bit_stb,
    output vsfm_sym_s        sym
);
    // word index to channel: 1-4 odd visual, 5 ir a,
    // 6-9 even visual, 10 ir b
    function automatic logic [3:0] word_map(input logic [3:0] w);
        logic [3:0] r;
        r = 4'h0;
        if (w == `VSFM_WORD_IR_A) begin
            r = 4'h8;
        end else if (w == `VSFM_WORD_LAST) begin
            r = 4'h9;
        end else if (w < `VSFM_WORD_IR_A) begin
            r = {1'b0, 3'((w - 4'h1) << 1)};
        end else begin
            r = {1'b0, 3'(((w - 4'h6) << 1) + 4'h1)};
        end
        return r;
    endfunction

    // next word index, skipping the cut range in half mode
    function automatic logic [3:0] next_word(input logic [3:0] w,
                                             input vsfm_mode_e m);
        logic [3:0] n;
        n = (w == `VSFM_WORD_LAST) ? `VSFM_WORD_FIRST : w + 4'h1;
        if (m == VSFM_MODE_HALF && n == `VSFM_WORD_CUT_LO) begin
            n = `VSFM_WORD_CUT_HI + 4'h1;
        end
        return n;
    endfunction

    // per-mode bit rate in Mb/s
    function automatic logic [7:0] mode_rate(input vsfm_mode_e m);
        return (m == VSFM_MODE_HALF) ? `VSFM_RATE_HALF : `VSFM_RATE_FULL;
    endfunction

    localparam int unsigned PRE_FULL = PREAMBLE_US * 28;
    localparam int unsigned PRE_HALF = PREAMBLE_US * 14;

    vsfm_mode_e    mode_r;      // mode of the running frame
    vsfm_fst_e     fst_r;       // frame serializer state
    vsfm_pst_e     pst_r;       // sample sequencer state
    logic [11:0]   id_r;        // captured line id
    logic [7:0]    acc_r;       // fractional rate accumulator
    logic          tick;        // one-cycle bit enable
    logic [8:0]    acc_sum;
    logic          start_p;     // frame start event
    logic [3:0]    widx_r;      // current word number
    logic [15:0]   samp_r;      // sample sets produced
    vsfm_word_s    word_r;      // converted word awaiting push
    vsfm_word_s    fifo_q;      // word at buffer head
    logic          fifo_rdy;
    logic          fifo_vld;
    logic          fifo_pop;
    logic [55:0]   sh_r;        // output shift register
    logic [16:0]   left_r;      // bits left in current field
    logic [19:0]   sent_r;      // video words taken
    logic [19:0]   total;
    logic          alt_r;       // preamble phase
    logic          half_r;      // first bit of dibit held
    logic          first_r;
    logic [1:0]    phase_r;     // carrier phase accumulator
    logic [1:0]    dbin;
    logic [1:0]    ph_nxt;
    logic [3:0]    wch;         // channel of the current word

    // decoded once, a function result cannot be bit-selected
    assign wch = word_map(widx_r);

    assign start_p     = (fst_r == F_IDLE) & line_start;
    assign mode_act    = mode_r;
    assign pair_sum_en = (mode_r == VSFM_MODE_HALF);
    assign frame_busy  = (fst_r != F_IDLE);
    assign total = 20'(SAMPLES_PER_LINE) *
                   ((mode_r == VSFM_MODE_HALF) ? 20'(`VSFM_WORDS_HALF)
                                               : 20'(`VSFM_WORDS_FULL));

    // latch mode only when a frame begins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= VSFM_MODE_FULL;
        end else if (start_p) begin
            mode_r <= vsfm_mode_e'(mode_cmd);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            id_r <= '0;
        end else if (start_p) begin
            id_r <= line_id;
        end
    end

    // bit enable: add rate, wrap at clock MHz
    assign acc_sum = {1'b0, acc_r} + {1'b0, mode_rate(mode_r)};
    assign tick    = frame_busy & (acc_sum >= {1'b0, `VSFM_CLK_MHZ});
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= '0;
        end else if (!frame_busy) begin
            acc_r <= '0;
        end else if (tick) begin
            acc_r <= 8'(acc_sum - {1'b0, `VSFM_CLK_MHZ});
        end else begin
            acc_r <= acc_sum[7:0];
        end
    end

    // sequencer: request, wait, push one word at a time
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pst_r    <= P_IDLE;
            widx_r   <= `VSFM_WORD_FIRST;
            samp_r   <= '0;
            conv_req <= '0;
            word_r   <= '0;
            grp_even <= 1'b0;
        end else begin
            conv_req.go <= 1'b0;
            case (pst_r)
                P_IDLE: begin
                    if (start_p) begin
                        widx_r <= `VSFM_WORD_FIRST;
                        samp_r <= '0;
                        pst_r  <= P_REQ;
                    end
                end
                P_REQ: begin
                    conv_req.go <= 1'b1;
                    conv_req.ir <= wch[3];
                    conv_req.ch <= wch[2:0];
                    conv_req.unit <= wch[3] ? ir_unit_sel : vis_unit_sel;
                    // even group only reached in full mode
                    if (!wch[3]) begin
                        grp_even <= wch[0];
                    end
                    pst_r <= P_WAIT;
                end
                P_WAIT: begin
                    if (conv_done) begin
                        word_r.ir <= conv_req.ir;
                        if (conv_req.ir) begin
                            word_r.code <= conv_req.unit ? conv_codes.ir_b
                                                         : conv_codes.ir_a;
                        end else begin
                            word_r.code <= {conv_req.unit ?
                                conv_codes.vis_b : conv_codes.vis_a, 2'b00};
                        end
                        pst_r <= P_PUSH;
                    end
                end
                P_PUSH: begin
                    // stalls here while the buffer is full
                    if (fifo_rdy) begin
                        widx_r <= next_word(widx_r, mode_r);
                        if (widx_r == `VSFM_WORD_LAST) begin
                            samp_r <= samp_r + 16'h1;
                        end
                        if (widx_r == `VSFM_WORD_LAST &&
                            samp_r == 16'(SAMPLES_PER_LINE - 1)) begin
                            pst_r <= P_IDLE;
                        end else begin
                            pst_r <= P_REQ;
                        end
                    end
                end
                default: pst_r <= P_IDLE;
            endcase
        end
    end

    // word buffer between converters and serializer
    vsfm_fifo #(
        .W ($bits(vsfm_word_s)),
        .D (`VSFM_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (pst_r == P_PUSH),
        .in_ready  (fifo_rdy),
        .in_data   (word_r),
        .out_valid (fifo_vld),
        .out_ready (fifo_pop),
        .out_data  (fifo_q)
    );

    assign fifo_pop = (fst_r == F_VIDEO) & tick & (left_r == '0) &
                      (sent_r != total);

    // frame serializer, msb first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fst_r    <= F_IDLE;
            sh_r     <= '0;
            left_r   <= '0;
            sent_r   <= '0;
            alt_r    <= 1'b0;
            ser_bit  <= 1'b0;
            bit_stb  <= 1'b0;
            underrun <= 1'b0;
        end else begin
            bit_stb <= tick;
            case (fst_r)
                F_IDLE: begin
                    if (start_p) begin
                        // preamble length from mode bit rate
                        left_r <= 17'(mode_cmd ? PRE_HALF : PRE_FULL);
                        alt_r    <= 1'b1;
                        sent_r   <= '0;
                        underrun <= 1'b0;
                        fst_r    <= F_PRE;
                    end
                end
                F_PRE: begin
                    if (tick) begin
                        ser_bit <= alt_r;
                        alt_r   <= ~alt_r;
                        left_r  <= left_r - 17'h1;
                        if (left_r == 17'h1) begin
                            sh_r   <= {`VSFM_SYNC_PAT, id_r};
                            left_r <= 17'(`VSFM_SYNC_W);
                            fst_r  <= F_SYNC;
                        end
                    end
                end
                F_SYNC: begin
                    if (tick) begin
                        ser_bit <= sh_r[55];
                        sh_r    <= {sh_r[54:0], 1'b0};
                        left_r  <= left_r - 17'h1;
                        if (left_r == 17'h1) begin
                            fst_r <= F_VIDEO;
                        end
                    end
                end
                F_VIDEO: begin
                    if (tick && left_r != '0) begin
                        ser_bit <= sh_r[55];
                        sh_r    <= {sh_r[54:0], 1'b0};
                        left_r  <= left_r - 17'h1;
                        if (left_r == 17'h1 && sent_r == total) begin
                            fst_r <= F_IDLE;
                        end
                    end else if (fifo_pop && fifo_vld) begin
                        // eight ir bits or six visual bits
                        ser_bit <= fifo_q.code[7];
                        sh_r    <= {fifo_q.code[6:0], 49'h0};
                        left_r  <= fifo_q.ir ? 17'h7 : 17'h5;
                        sent_r  <= sent_r + 20'h1;
                    end else if (fifo_pop) begin
                        // starved: send a zero and flag it
                        ser_bit  <= 1'b0;
                        underrun <= 1'b1;
                    end
                end
                default: fst_r <= F_IDLE;
            endcase
        end
    end

    // quaternary differential encoding of bit pairs
    assign dbin   = {first_r, first_r ^ ser_bit};
    assign ph_nxt = phase_r + dbin;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_r  <= 1'b0;
            first_r <= 1'b0;
            phase_r <= '0;
            sym     <= '0;
        end else begin
            sym.stb <= 1'b0;
            if (start_p) begin
                // dibits align to the frame
                half_r <= 1'b0;
            end else if (bit_stb) begin
                half_r <= ~half_r;
                if (!half_r) begin
                    first_r <= ser_bit;
                end else begin
                    // gray dibit adds to phase, phase sent gray
                    phase_r <= ph_nxt;
                    sym.stb <= 1'b1;
                    sym.i   <= ph_nxt[1];
                    sym.q   <= ph_nxt[1] ^ ph_nxt[0];
                end
            end
        end
    end
endmodule // vsfm_top

// ==== rtl/vsfm_defs.svh ====
// constants of the video sample frame multiplexer
`ifndef VSFM_DEFS_SVH
`define VSFM_DEFS_SVH
`define VSFM_CLK_MHZ       8'd100
`define VSFM_RATE_FULL     8'd28
`define VSFM_RATE_HALF     8'd14
`define VSFM_PRE_US        2000
`define VSFM_SAMPLES       2048
`define VSFM_SYNC_W        56
`define VSFM_SYNC_PAT      44'hfa5_c3e9_1b7d
`define VSFM_ID_W          12
`define VSFM_VIS_W         6
`define VSFM_IR_W          8
`define VSFM_WORD_FIRST    4'd1
`define VSFM_WORD_LAST     4'd10
`define VSFM_WORD_IR_A     4'd5
`define VSFM_WORD_CUT_LO   4'd6
`define VSFM_WORD_CUT_HI   4'd9
`define VSFM_WORDS_FULL    5'd10
`define VSFM_WORDS_HALF    5'd6
`define VSFM_FIFO_DEPTH    8
`endif

// ==== rtl/vsfm_pkg.sv ====
// types of the video sample frame multiplexer
package vsfm_pkg;
    typedef enum logic {VSFM_MODE_FULL, VSFM_MODE_HALF} vsfm_mode_e;
    typedef enum logic [1:0] {F_IDLE, F_PRE, F_SYNC, F_VIDEO} vsfm_fst_e;
    typedef enum logic [1:0] {P_IDLE, P_REQ, P_WAIT, P_PUSH} vsfm_pst_e;
    // one converted sample: ir flag and left-aligned code
    typedef struct packed {
        logic       ir;
        logic [7:0] code;
    } vsfm_word_s;
    // codes offered by both converter pairs
    typedef struct packed {
        logic [5:0] vis_a;
        logic [5:0] vis_b;
        logic [7:0] ir_a;
        logic [7:0] ir_b;
    } vsfm_codes_s;
    // conversion request to the analog front end
    typedef struct packed {
        logic       go;
        logic       unit;
        logic       ir;
        logic [2:0] ch;
    } vsfm_req_s;
    // quadriphase symbol
    typedef struct packed {
        logic stb;
        logic i;
        logic q;
    } vsfm_sym_s;
endpackage

// ==== sim/vsfm_conv_model.sv ====
// behavioural model of the redundant converter front end
`timescale 1ns/10ps
module vsfm_conv_model
    import vsfm_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // request from the sequencer, answer delay from the bench
    input  vsfm_req_s       conv_req,
    input  wire logic [7:0] dly,
    // answer
    output logic            conv_done,
    output vsfm_codes_s     conv_codes
);
    vsfm_req_s   req_r;  // request being converted
    logic [7:0]  cnt_r;  // cycles left until done
    logic        busy_r; // conversion running
    vsfm_codes_s val;    // codes of the held request

    // codes tell channel and unit apart so a wrong pick shows
    assign val = '{vis_a: {3'b101, req_r.ch}, vis_b: {3'b010, req_r.ch},
                   ir_a: {7'h66, req_r.ch[0]}, ir_b: {7'h19, req_r.ch[0]}};
    // outside done the bus carries garbage, not the last codes
    assign conv_codes = conv_done ? val : ~val;

    // one conversion at a time, done after dly cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r    <= 1'b0;
            cnt_r     <= 8'h00;
            conv_done <= 1'b0;
            req_r     <= '0;
        end else begin
            conv_done <= 1'b0;
            if (conv_req.go) begin
                busy_r <= 1'b1;
                cnt_r  <= dly;
                req_r  <= conv_req;
            end else if (busy_r) begin
                // slow answers starve the buffer on purpose
                if (cnt_r <= 8'h01) begin
                    conv_done <= 1'b1;
                    busy_r    <= 1'b0;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule // vsfm_conv_model

// ==== sim/vsfm_top_props.sv ====
// checker of the frame multiplexer port behaviour
`timescale 1ns/10ps
module vsfm_top_props
    import vsfm_pkg::*;
(
    // clock and reset
    input  wire logic  clk,
    input  wire logic  arst_n,
    // commands and selects
    input  wire logic  line_start,
    input  wire logic  vis_unit_sel,
    input  wire logic  ir_unit_sel,
    // converter side
    input  wire logic  conv_done,
    input  vsfm_req_s  conv_req,
    // status and stream
    input  wire logic  pair_sum_en,
    input  wire logic  mode_act,
    input  wire logic  frame_busy,
    input  wire logic  bit_stb,
    input  vsfm_sym_s  sym
);
    // single clock domain throughout
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_frame_start_taken: assert property (
        line_start && !frame_busy |=> frame_busy)
        else $error("frame not started");
    a_go_after_done: assert property (
        conv_done |=> !conv_req.go)
        else $error("request too soon after done");
    a_full_bit_gap: assert property (
        bit_stb |=> !bit_stb [*2])
        else $error("bits closer than full rate");
    a_half_bit_gap: assert property (
        bit_stb && frame_busy && mode_act |=> !bit_stb [*6])
        else $error("bits closer than half rate");
    a_symbol_follows_bit: assert property (
        sym.stb |-> $past(bit_stb))
        else $error("symbol without a bit before");
    a_pair_sum_mode: assert property (
        frame_busy && $past(frame_busy) |-> pair_sum_en == mode_act)
        else $error("pair sum disagrees with mode");
    a_half_odd_only: assert property (
        conv_req.go && mode_act |-> conv_req.ir || !conv_req.ch[0])
        else $error("even group requested in half mode");
    a_mode_held: assert property (
        frame_busy && $past(frame_busy) |-> $stable(mode_act))
        else $error("mode changed inside a frame");
    a_unit_select: assert property (
        conv_req.go && $stable(vis_unit_sel) && $stable(ir_unit_sel)
        |-> conv_req.unit == (conv_req.ir ? ir_unit_sel : vis_unit_sel))
        else $error("wrong converter unit");
    // half mode frame seen
    c_half_frame: cover property (frame_busy && mode_act);
endmodule // vsfm_top_props

bind vsfm_top vsfm_top_props u_vsfm_top_props (.clk(clk), .arst_n(arst_n),
    .line_start(line_start), .vis_unit_sel(vis_unit_sel),
    .ir_unit_sel(ir_unit_sel), .conv_done(conv_done),
    .conv_req(conv_req), .pair_sum_en(pair_sum_en), .mode_act(mode_act),
    .frame_busy(frame_busy), .bit_stb(bit_stb), .sym(sym));

// ==== sim/vsfm_top_bench.sv ====
// self-checking bench of the video sample frame multiplexer
`timescale 1ns/10ps
`include "vsfm_defs.svh"
module vsfm_top_bench;
    import vsfm_pkg::*;
    localparam int PRE  = 2; // short preamble, microseconds
    localparam int SETS = 2; // sample sets per line
    logic        clk;
    logic        arst_n;
    logic        mode_cmd;
    logic        vis_unit_sel;
    logic        ir_unit_sel;
    logic        line_start;
    logic [11:0] line_id;
    logic        conv_done;
    vsfm_codes_s conv_codes;
    vsfm_req_s   conv_req;
    logic        pair_sum_en;
    logic        grp_even;
    logic        mode_act;
    logic        frame_busy;
    logic        underrun;
    logic        ser_bit;
    logic        bit_stb;
    vsfm_sym_s   sym;
    logic [7:0]  dly;     // converter answer delay
    logic [1:0]  phase;   // expected modulator phase
    logic        got_q[$]; // captured bits of a frame
    logic        exp_q[$]; // expected bits of a frame
    int          fails;
    int          compares;
    int          cycles;
    int          syms;    // symbols seen in a frame

    vsfm_top #(.PREAMBLE_US(PRE), .SAMPLES_PER_LINE(SETS)) u_vsfm_top (
        .clk(clk), .arst_n(arst_n), .mode_cmd(mode_cmd),
        .vis_unit_sel(vis_unit_sel), .ir_unit_sel(ir_unit_sel),
        .line_start(line_start), .line_id(line_id), .conv_done(conv_done),
        .conv_codes(conv_codes), .conv_req(conv_req),
        .pair_sum_en(pair_sum_en), .grp_even(grp_even), .mode_act(mode_act),
        .frame_busy(frame_busy), .underrun(underrun), .ser_bit(ser_bit),
        .bit_stb(bit_stb), .sym(sym));
    vsfm_conv_model u_vsfm_conv_model (.clk(clk), .arst_n(arst_n),
        .conv_req(conv_req), .dly(dly), .conv_done(conv_done),
        .conv_codes(conv_codes));

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, frames take about 860 (full) to 1170 (half) cycles, a starved one longer
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            print_verdict();
        end
    end

    // capture bits; track differential phase per dibit
    always @(negedge clk) begin
        if (!arst_n) begin
            phase = 2'b00;
        end else begin
            if (bit_stb === 1'b1)
                got_q.push_back(ser_bit);
            // one symbol per dibit, half the bit rate
            if (sym.stb === 1'b1)
                syms++;
            if (sym.stb === 1'b1 && got_q.size() >= 2) begin
                phase = phase + {got_q[$-1], got_q[$-1] ^ got_q[$]};
                chk({sym.i, sym.q}, {phase[1], ^phase});
            end
        end
    end

    task automatic push_bits(input logic [55:0] v, input int n);
        for (int k = n - 1; k >= 0; k--)
            exp_q.push_back(v[k]);
    endtask

    // expected frame: preamble, sync and id, then words msb first
    task automatic build(input logic m, input logic [11:0] id,
                         input logic vu, input logic iu);
        int ford[10] = '{0, 2, 4, 6, 8, 1, 3, 5, 7, 9};
        int c;
        exp_q.delete();
        for (int k = 0; k < PRE * (m ? 14 : 28); k++)
            exp_q.push_back(~k[0]);
        push_bits({`VSFM_SYNC_PAT, id}, 56);
        for (int s = 0; s < SETS; s++) begin
            for (int w = 0; w < 10; w++) begin
                // half mode drops words six to nine
                if (m && w >= 5 && w <= 8)
                    continue;
                c = ford[w];
                if (c >= 8)
                    push_bits(iu ? {7'h19, c[0]} : {7'h66, c[0]}, 8);
                else
                    push_bits(vu ? {3'b010, c[2:0]} : {3'b101, c[2:0]}, 6);
            end
        end
    endtask

    // one frame; poke flips mode and restarts inside it
    task automatic run_frame(input logic m, input logic [11:0] id,
                             input logic vu, input logic iu,
                             input logic poke, input logic cmp);
        int dur;
        int ideal;
        dur = 0;
        build(m, id, vu, iu);
        mode_cmd     <= m;
        line_id      <= id;
        vis_unit_sel <= vu;
        ir_unit_sel  <= iu;
        got_q.delete();
        syms = 0;
        @(posedge clk);
        line_start <= 1'b1;
        @(posedge clk);
        line_start <= 1'b0;
        // busy only settles after the start edge
        @(negedge clk);
        while (frame_busy !== 1'b0 && dur < 20000) begin
            @(posedge clk);
            dur++;
            if (poke && dur == 200) begin
                mode_cmd   <= ~m;
                line_start <= 1'b1;
            end
            if (poke && dur == 201)
                line_start <= 1'b0;
        end
        chk(dur < 20000, 1'b1);
        // let the last symbol strobe pass first
        repeat (2) @(negedge clk);
        chk(mode_act, m);
        if (cmp) begin
            chk(got_q.size(), exp_q.size());
            chk(syms, got_q.size() / 2);
            for (int k = 0; k < exp_q.size() && k < got_q.size(); k++)
                chk(got_q[k], exp_q[k]);
            ideal = exp_q.size() * 100 / (m ? 14 : 28);
            chk(dur < ideal + 12 && dur > ideal - 12, 1'b1);
        end
        repeat (3) @(posedge clk);
    endtask

    // full mode, unit a visual, unit b infrared
    task automatic t_full;
        run_frame(1'b0, 12'ha5c, 1'b0, 1'b1, 1'b0, 1'b1);
        chk(underrun, 1'b0);
        chk(pair_sum_en, 1'b0);
        chk(grp_even, 1'b1);
    endtask

    // half mode, other units, paired visuals
    task automatic t_half;
        run_frame(1'b1, 12'h3c7, 1'b1, 1'b0, 1'b0, 1'b1);
        chk(pair_sum_en, 1'b1);
        chk(grp_even, 1'b0);
    endtask

    // mode command and restart inside a frame take no effect
    task automatic t_mid_change;
        run_frame(1'b0, 12'hf01, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(frame_busy, 1'b0);
    endtask

    // slow converter starves the buffer, next frame recovers
    task automatic t_starve;
        dly <= 8'd80;
        run_frame(1'b0, 12'h0ff, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(underrun, 1'b1);
        dly <= 8'd4;
        run_frame(1'b0, 12'h800, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(underrun, 1'b0);
    endtask

    initial begin
        clk          = 1'b0;
        arst_n       = 1'b0;
        mode_cmd     = 1'b0;
        vis_unit_sel = 1'b0;
        ir_unit_sel  = 1'b0;
        line_start   = 1'b0;
        line_id      = 12'h000;
        dly          = 8'd4;
        fails        = 0;
        compares     = 0;
        cycles       = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk({frame_busy, bit_stb, underrun, mode_act}, 4'h0);
        @(posedge clk);
        t_full();
        t_half();
        t_mid_change();
        t_starve();
        print_verdict();
    end
endmodule // vsfm_top_bench
